// *** core/aca_reply_lockout.sv ***
// All-call reply decision with sixteen lockout timers and site address encoding
//
// How it works
// (R1) Surveillance or Comm-A with protocol code 1 sets the non-selective lockout.
// (R2) Non-selective lockout lasts about 18 seconds, then lapses unless renewed.
// (R3) Ground sensor renews each lockout every antenna scan.
// (R4) Site acquisition uses format 11; its identity field holds the site address.
// (R5) Site addresses 1..15 are selective; zero means non-selective interrogation.
// (R6) Answer format 11 only when not locked out to that site.
// (R7) Sixteen independent timers: fifteen sites plus one non-selective.
// (R8) Encoding address is the 4-bit site address zero-filled to 24 bits.
// (R9) Parity field is encoded with that derived address, like own address.
// (R10) Parity field is address XOR parity bits over preceding reply bits.
// (R11) Reply carries 3-bit capability and 24-bit own address ahead of parity.
// (R12) First four designator bits are the site address, whatever the code.
// (R13) Designator code 1 or 7 with lockout bit 1 sets that site's lockout.
// (R14) Each site lockout lasts about 18 seconds unless renewed.
// (R15) Answer Mode S-only all-call, never the short fourth pulse all-call.
// (R16) Probability codes 0..4 mean 1, 1/2, 1/4, 1/8, 1/16.
// (R17) For codes 0..4 an active applicable lockout always suppresses the reply.
// (R18) Without lockout, reply only when the random draw meets the probability.
// (R19) Codes 8..12 give the same probabilities but ignore lockout.
// (R20) Multisite sensor decodes replies with its own identity as address.
// (R21) Initial acquisition: 4-6 all-calls per dwell, probability raised over scans.
// (R22) Three or more correlated garbled replies lead to probability 1/2 next scan.
// (R23) Timers reload fully on set or renewal and count down on a slow tick.
// (R24) Draw is low four bits of a free-running LFSR against a code threshold.
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module aca_reply_lockout #(
   parameter int TICK_CYC = aca_pkg::TICK_CYCLES,
   parameter int LOCK_TICKS = aca_pkg::LOCKOUT_TICKS
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [aca_pkg::REG_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Decoded interrogation, one-cycle strobe from the uplink decoder
   input wire logic ifc_valid,
   input wire logic [4:0] ifc_uf,
   input wire logic ifc_short_p4,
   input wire logic [2:0] ifc_pc,
   input wire logic [2:0] ifc_di,
   input wire logic [15:0] ifc_sd,
   input wire logic [3:0] ifc_pr,
   input wire logic [3:0] ifc_ii,
   // All-call reply towards the encoder and the external parity generator
   output logic [31:0] reply_data,
   input wire logic [23:0] parity_in,
   output logic reply_valid,
   output logic [23:0] reply_pi
);
   import aca_pkg::*;

   localparam int TICK_W = $clog2(TICK_CYC + 1);

   generate
      if (TICK_CYC < 1 || LOCK_TICKS < 1) begin : g_bad_time
         $error("tick and lockout counts must be at least one");
      end
   endgenerate

   // All sixteen timers share one width, so the lockout count must fit it
   generate
      if (LOCK_TICKS >= (1 << TIMER_W)) begin : g_bad_span
         $error("lockout count does not fit the timer width");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Reset release
   // Release is synchronised so every flop on rst_i_n leaves reset on the same edge
   logic rst_meta_q;
   logic rst_sync_q;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   wire logic rst_i_n = rst_sync_q;

   ////////////////////////////////////////////////////////////////////////////
   // Slow time base for the lockout timers
   logic [TICK_W-1:0] div_q;
   logic tick_q;

   always_ff @(posedge ref_clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         div_q <= '0;
         tick_q <= 1'b0;
      end else if (div_q == TICK_W'(TICK_CYC - 1)) begin
         div_q <= '0;
         tick_q <= 1'b1;
      end else begin
         div_q <= div_q + 1'b1;
         tick_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [23:0] own_addr_q;
   logic [2:0] ca_q;
   logic en_q;
   logic [15:0] reply_cnt_q;
   logic [NUM_TIMERS-1:0] lock_act;

   always_ff @(posedge ref_clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         own_addr_q <= OWN_ADDR_RESET;
         ca_q <= CA_RESET;
         en_q <= EN_RESET;
      end else if (reg_wr) begin
         if (reg_addr == REG_OWN_ADDR) begin
            own_addr_q <= reg_wdata[23:0];
         end
         if (reg_addr == REG_CTRL) begin
            ca_q <= reg_wdata[CTRL_CA_MSB:CTRL_CA_LSB];
            en_q <= reg_wdata[CTRL_EN_BIT];
         end
      end
   end

   // Unmapped addresses read as zero
   always_ff @(posedge ref_clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         reg_rdata <= 32'h0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            REG_OWN_ADDR: reg_rdata <= {8'h0, own_addr_q};
            REG_CTRL: reg_rdata <= {28'h0, en_q, ca_q};
            REG_LOCK_STAT: reg_rdata <= {16'h0, lock_act};
            REG_REPLY_CNT: reg_rdata <= {16'h0, reply_cnt_q};
            default: reg_rdata <= 32'h0;
         endcase
      end else begin
         reg_rdata <= 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Lockout commands
   wire logic surv_uf = (ifc_uf == UF_SURV_ALT) || (ifc_uf == UF_SURV_ID) ||
      (ifc_uf == UF_COMMA_ALT) || (ifc_uf == UF_COMMA_ID);
   wire logic [3:0] iis = ifc_sd[SD_IIS_MSB:SD_IIS_LSB]; // [R12]
   wire logic nonsel_set = ifc_valid && surv_uf && ifc_pc == PC_NONSEL_LOCK; // [R1]
   wire logic di_lock = (ifc_di == DI_MULTISITE) || (ifc_di == DI_EXT_READOUT); // [R13]
   // Site zero is the non-selective index, so a zero site field never locks anything
   wire logic site_set = ifc_valid && surv_uf && ifc_sd[SD_LOS_BIT] && di_lock &&
      iis != 4'h0; // [R13] [R5]
   logic [NUM_TIMERS-1:0] lock_load;

   always_comb begin
      lock_load = '0;
      lock_load[NONSEL_IDX] = nonsel_set;
      if (site_set) begin
         lock_load[iis] = 1'b1; // [R13] [R5]
      end
   end

   // Index 0 is the non-selective timer, 1..15 follow the site address
   genvar gi;
   generate
      for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_timer
         aca_lock_timer #(
            .W(TIMER_W),
            .LOAD(LOCK_TICKS)
         ) u_timer ( // [R7] [R2] [R14] [R23]
            .clk(ref_clk),
            .rst_n(rst_i_n),
            .tick(tick_q),
            .load(lock_load[gi]),
            .active(lock_act[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Random source, free running so the draw is independent of arrival time
   logic [15:0] lfsr_q;

   always_ff @(posedge ref_clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         lfsr_q <= LFSR_SEED;
      end else if (lfsr_q[0]) begin
         lfsr_q <= (lfsr_q >> 1) ^ LFSR_TAPS;
      end else begin
         lfsr_q <= lfsr_q >> 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reply decision
   wire logic allcall = ifc_valid && ifc_uf == UF_ALLCALL && !ifc_short_p4; // [R4] [R15]
   // Site zero reads the non-selective timer, so one lookup serves both cases
   wire logic lock_hit = lock_act[ifc_ii]; // [R5] [R6]
   wire logic pr_plain = ifc_pr <= PR_MAX_STEP;
   wire logic pr_ovr = ifc_pr >= PR_OVR_BASE && ifc_pr <= PR_OVR_MAX;
   wire logic [2:0] pr_step = pr_plain ? ifc_pr[2:0] : 3'(ifc_pr - PR_OVR_BASE);
   // Threshold is 16 >> step, so code 0 always passes and code 4 passes 1 in 16
   wire logic [4:0] pr_limit = 5'h10 >> pr_step; // [R16] [R19]
   wire logic draw_ok = {1'b0, lfsr_q[3:0]} < pr_limit; // [R24] [R18]
   // Codes 5..7 and 13..15 are undefined and get no reply
   wire logic go = allcall && en_q && draw_ok &&
      ((pr_plain && !lock_hit) || pr_ovr); // [R17] [R19]

   aca_stage_t stage_q;
   logic [23:0] enc_addr_q;

   always_ff @(posedge ref_clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         stage_q <= STG_IDLE;
      end else begin
         unique case (stage_q)
            STG_IDLE: stage_q <= go ? STG_ENCODE : STG_IDLE;
            STG_ENCODE: stage_q <= go ? STG_ENCODE : STG_IDLE;
         endcase
      end
   end

   // Data bits ahead of parity; the parity generator reads them back as parity_in
   always_ff @(posedge ref_clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         reply_data <= 32'h0;
         enc_addr_q <= 24'h0;
      end else if (go) begin
         reply_data <= {DF_ALLCALL, ca_q, own_addr_q}; // [R11]
         enc_addr_q <= {20'h0, ifc_ii}; // [R8]
      end
   end

   always_ff @(posedge ref_clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         reply_valid <= 1'b0;
         reply_pi <= 24'h0;
      end else begin
         reply_valid <= (stage_q == STG_ENCODE);
         if (stage_q == STG_ENCODE) begin
            reply_pi <= parity_in ^ enc_addr_q; // [R9] [R10]
         end
      end
   end

   // Wraps silently; software takes differences between two reads
   always_ff @(posedge ref_clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         reply_cnt_q <= 16'h0;
      end else if (stage_q == STG_ENCODE) begin
         reply_cnt_q <= reply_cnt_q + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_i_n);

   wire logic pr_bad = (ifc_pr > PR_MAX_STEP && ifc_pr < PR_OVR_BASE) || ifc_pr > PR_OVR_MAX;

   a_reply_cause: assert property (reply_valid |-> // [R4] [R15]
      $past(ifc_valid && ifc_uf == UF_ALLCALL && !ifc_short_p4, 2))
      else $error("reply without a Mode S-only all-call");
   a_lock_blocks: assert property (allcall && pr_plain && lock_hit |=> // [R6] [R17]
      stage_q == STG_IDLE ##1 !reply_valid)
      else $error("locked out site still answered");
   a_override_reply: assert property (allcall && en_q && ifc_pr == PR_OVR_BASE |=> // [R19]
      stage_q == STG_ENCODE ##1 reply_valid)
      else $error("override code 8 did not answer");
   a_prob_one: assert property (allcall && en_q && ifc_pr == 4'h0 && !lock_hit |=> // [R16] [R18]
      ##1 reply_valid)
      else $error("code 0 without lockout did not answer");
   a_quarter_draw: assert property (allcall && en_q && ifc_pr == 4'h2 && !lock_hit |=> // [R24]
      (stage_q == STG_ENCODE) == ($past(lfsr_q[3:0]) < 4'h4))
      else $error("quarter draw decision wrong");
   a_bad_code: assert property (ifc_valid && pr_bad |=> stage_q == STG_IDLE) // [R16]
      else $error("undefined probability code answered");
   a_pi_overlay: assert property (reply_valid |-> // [R8] [R9] [R10]
      reply_pi == ($past(parity_in) ^ {20'h0, $past(ifc_ii, 2)}))
      else $error("parity field not overlaid with site address");
   a_nonsel_set: assert property (nonsel_set |-> ##1 lock_act[NONSEL_IDX]) // [R1]
      else $error("non-selective lockout not set");
   a_site_set: assert property (site_set |=> lock_act[$past(iis)]) // [R13] [R12]
      else $error("site lockout not set");
   a_lock_lapse: assert property ($fell(lock_act[NONSEL_IDX]) |-> $past(tick_q)) // [R2] [R23]
      else $error("lockout ended off the time base");
   a_data_fields: assert property (go |=> // [R11]
      reply_data == {DF_ALLCALL, $past(ca_q), $past(own_addr_q)})
      else $error("reply data fields wrong");
   a_override_any: assert property (allcall && en_q && pr_ovr && draw_ok |=> // [R19]
      stage_q == STG_ENCODE)
      else $error("override code did not ignore lockout");
   a_short_quiet: assert property (ifc_valid && ifc_short_p4 |=> stage_q == STG_IDLE) // [R15]
      else $error("short fourth pulse all-call answered");
   a_off_quiet: assert property (!en_q |=> stage_q == STG_IDLE)
      else $error("disabled block answered");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data outside its cycle");

   // Check-only age of each timer since its last load, saturating so it never wraps
   localparam logic [31:0] AGE_HOLD = 32'((LOCK_TICKS - 1) * TICK_CYC);
   localparam logic [31:0] AGE_DONE = 32'(LOCK_TICKS * TICK_CYC);

   generate
      for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_age
         logic [31:0] age_q;

         always_ff @(posedge ref_clk or negedge rst_i_n) begin
            if (!rst_i_n) begin
               age_q <= '1;
            end else if (lock_load[gi]) begin
               age_q <= 32'h0;
            end else if (age_q != '1) begin
               age_q <= age_q + 1'b1;
            end
         end

         a_timer_load: assert property (lock_load[gi] |=> lock_act[gi]) // [R7] [R23]
            else $error("lockout timer did not start on load");
         a_lock_hold: assert property (age_q < AGE_HOLD |-> lock_act[gi]) // [R2] [R14]
            else $error("lockout ended too early");
         a_lock_end: assert property (age_q >= AGE_DONE |-> !lock_act[gi]) // [R2] [R14]
            else $error("lockout outlived its time");
      end
   endgenerate

   c_site_reply: cover property (allcall && ifc_ii != 4'h0 ##2 reply_valid);
   c_prob_half: cover property (allcall && ifc_pr == 4'h1 ##2 reply_valid);
   c_site_locked: cover property (site_set ##[1:20] allcall && lock_hit);
   c_override: cover property (allcall && pr_ovr && lock_hit ##2 reply_valid);
   c_lapse: cover property ($fell(lock_act[NONSEL_IDX]));
endmodule // aca_reply_lockout
`default_nettype wire

// *** core/aca_pkg.sv ***
// Constants, register map and types shared by the all-call reply lockout block
package aca_pkg;
   // Time base: clock period, lockout tick period and lockout length
   localparam int CLK_PERIOD_NS = 50;
   localparam int TICK_PERIOD_US = 1000;
   localparam int LOCKOUT_S = 18;
   localparam int TICK_CYCLES = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
   localparam int LOCKOUT_TICKS = LOCKOUT_S * 1000000 / TICK_PERIOD_US;
   localparam int TIMER_W = 15;
   localparam int NUM_TIMERS = 16;
   localparam int NONSEL_IDX = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Interrogation and reply field codes
   localparam logic [4:0] UF_SURV_ALT = 5'h04;
   localparam logic [4:0] UF_SURV_ID = 5'h05;
   localparam logic [4:0] UF_COMMA_ALT = 5'h14;
   localparam logic [4:0] UF_COMMA_ID = 5'h15;
   localparam logic [4:0] UF_ALLCALL = 5'h0b;
   localparam logic [4:0] DF_ALLCALL = 5'h0b;
   localparam logic [2:0] PC_NONSEL_LOCK = 3'h1;
   localparam logic [2:0] DI_MULTISITE = 3'h1;
   localparam logic [2:0] DI_EXT_READOUT = 3'h7;
   localparam int SD_IIS_MSB = 15;
   localparam int SD_IIS_LSB = 12;
   localparam int SD_LOS_BIT = 11;
   localparam logic [3:0] PR_MAX_STEP = 4'h4;
   localparam logic [3:0] PR_OVR_BASE = 4'h8;
   localparam logic [3:0] PR_OVR_MAX = 4'hc;

   ////////////////////////////////////////////////////////////////////////////
   // Register map, fields and reset values
   localparam int REG_ADDR_W = 4;
   localparam logic [3:0] REG_OWN_ADDR = 4'h0;
   localparam logic [3:0] REG_CTRL = 4'h4;
   localparam logic [3:0] REG_LOCK_STAT = 4'h8;
   localparam logic [3:0] REG_REPLY_CNT = 4'hc;
   localparam int CTRL_CA_LSB = 0;
   localparam int CTRL_CA_MSB = 2;
   localparam int CTRL_EN_BIT = 3;
   localparam logic [23:0] OWN_ADDR_RESET = 24'h000000;
   localparam logic [2:0] CA_RESET = 3'h0;
   localparam logic EN_RESET = 1'b1;

   // Random source
   localparam logic [15:0] LFSR_SEED = 16'hace1;
   localparam logic [15:0] LFSR_TAPS = 16'hb400;

   typedef enum logic {STG_IDLE, STG_ENCODE} aca_stage_t;
endpackage

// *** core/aca_lock_timer.sv ***
// One lockout timer: reload on set, count down on each time-base tick
`timescale 1ns/1ps
`default_nettype none
module aca_lock_timer #(
   parameter int W = 15,
   parameter int LOAD = 18000
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic load,
   output logic active
);
   logic [W-1:0] cnt_q;

   generate
      if (LOAD < 1 || LOAD >= (1 << W)) begin : g_bad_load
         $error("lock timer load does not fit its counter");
      end
   endgenerate

   // Load wins over a tick in the same cycle so a renewal is never lost
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (load) begin
         cnt_q <= W'(LOAD);
      end else if (tick && cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   assign active = (cnt_q != '0);
endmodule // aca_lock_timer
`default_nettype wire

// *** bench/aca_sensor_model.sv ***
// Ground interrogator model: uplink field strobes and the downlink parity source
`timescale 1ns/1ps
`default_nettype none
module aca_sensor_model (
   input wire logic ref_clk,
   output var logic ifc_valid,
   output var logic [4:0] ifc_uf,
   output var logic ifc_short_p4,
   output var logic [2:0] ifc_pc,
   output var logic [2:0] ifc_di,
   output var logic [15:0] ifc_sd,
   output var logic [3:0] ifc_pr,
   output var logic [3:0] ifc_ii,
   input wire logic [31:0] reply_data,
   output logic [23:0] parity_in
);
   // Stand-in parity over the reply bits ahead of the parity field
   assign parity_in = reply_data[23:0] ^ {3{reply_data[31:24]}};
   initial begin
      ifc_valid = 1'b0;
      {ifc_uf, ifc_short_p4, ifc_pc, ifc_di, ifc_sd, ifc_pr, ifc_ii} = 36'h0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // One strobe cycle; fields are inverted afterwards so stale values never pass
   task automatic send(input logic [35:0] f);
      @(posedge ref_clk);
      ifc_valid <= 1'b1;
      {ifc_uf, ifc_short_p4, ifc_pc, ifc_di, ifc_sd, ifc_pr, ifc_ii} <= f;
      @(posedge ref_clk);
      ifc_valid <= 1'b0;
      {ifc_uf, ifc_short_p4, ifc_pc, ifc_di, ifc_sd, ifc_pr, ifc_ii} <= ~f;
   endtask
endmodule // aca_sensor_model
`default_nettype wire

// *** bench/aca_reply_lockout_tb_top.sv ***
// Self-checking bench for the all-call reply lockout block
`timescale 1ns/1ps
`default_nettype none
module aca_reply_lockout_tb_top;
   import aca_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata, reply_data;
   logic ifc_valid, ifc_short_p4, reply_valid;
   logic [4:0] ifc_uf;
   logic [2:0] ifc_pc, ifc_di;
   logic [15:0] ifc_sd;
   logic [3:0] ifc_pr, ifc_ii;
   logic [23:0] parity_in, reply_pi;
   logic [31:0] w;
   int error_cnt = 0;
   int compares = 0;
   always #25 ref_clk = ~ref_clk;
   // Short time base keeps each lockout near 80 cycles
   aca_reply_lockout #(.TICK_CYC(4), .LOCK_TICKS(20)) u_dut (.ref_clk, .rst_n, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ifc_valid, .ifc_uf, .ifc_short_p4, .ifc_pc,
      .ifc_di, .ifc_sd, .ifc_pr, .ifc_ii, .reply_data, .parity_in, .reply_valid, .reply_pi);
   aca_sensor_model u_s (.ref_clk, .ifc_valid, .ifc_uf, .ifc_short_p4, .ifc_pc, .ifc_di,
      .ifc_sd, .ifc_pr, .ifc_ii, .reply_data, .parity_in);
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [35:0] ac(logic [3:0] pr, logic [3:0] ii);
      return {UF_ALLCALL, 1'b0, 3'h0, 3'h0, 16'h0, pr, ii};
   endfunction
   function automatic logic [35:0] lk(logic [4:0] uf, logic [2:0] pc, logic [2:0] di,
         logic [15:0] sd);
      return {uf, 1'b0, pc, di, sd, 8'h0};
   endfunction
   function automatic logic [31:0] pi(logic [31:0] v, logic [3:0] ii);
      return {8'h0, v[23:0] ^ {3{v[31:24]}} ^ {20'h0, ii}};
   endfunction
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
         error_cnt++;
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // Counts reply pulses in the window after one interrogation
   task automatic ask(input logic [35:0] f, input logic [3:0] exp, input string nm);
      logic [3:0] n;
      n = 4'h0;
      u_s.send(f);
      repeat (4) begin
         @(posedge ref_clk);
         #1 n += {3'h0, reply_valid};
      end
      chk(nm, {28'h0, exp}, {28'h0, n});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic [31:0] d;
      rd(REG_OWN_ADDR, d);
      chk("own_addr", 32'h0, d);
      rd(REG_CTRL, d);
      chk("ctrl", 32'h8, d);
      wr(REG_LOCK_STAT, 32'hffff);
      rd(REG_LOCK_STAT, d);
      chk("lock_stat", 32'h0, d);
      rd(REG_REPLY_CNT, d);
      chk("reply_cnt", 32'h0, d);
      rd(4'h2, d);
      chk("unmapped", 32'h0, d);
      $display("t_reset done");
   endtask
   task automatic t_basic;
      logic [31:0] d;
      wr(REG_OWN_ADDR, 32'h00a5c3e1);
      wr(REG_CTRL, 32'hd);
      w = {DF_ALLCALL, 3'h5, 24'ha5c3e1};
      ask(ac(4'h0, 4'h5), 4'h1, "reply_once");
      chk("reply_data", w, reply_data);
      chk("reply_pi", pi(w, 4'h5), {8'h0, reply_pi});
      rd(REG_REPLY_CNT, d);
      chk("reply_cnt", 32'h1, d);
      $display("t_basic done");
   endtask
   task automatic t_refuse;
      logic [3:0] bad [6] = '{4'h5, 4'h6, 4'h7, 4'hd, 4'he, 4'hf};
      ask(ac(4'h0, 4'h5) | (36'h1 << 30), 4'h0, "short_p4");
      ask(ac(4'h0, 4'h5) ^ {5'h0f, 31'h0}, 4'h0, "uf_other");
      foreach (bad[i]) ask(ac(bad[i], 4'h5), 4'h0, "pr_unused");
      wr(REG_CTRL, 32'h5);
      ask(ac(4'h0, 4'h5), 4'h0, "disabled");
      wr(REG_CTRL, 32'hd);
      $display("t_refuse done");
   endtask
   task automatic t_site;
      logic [31:0] d;
      ask(lk(UF_SURV_ALT, 3'h0, DI_MULTISITE, 16'h3800), 4'h0, "set3");
      ask(lk(UF_COMMA_ID, 3'h0, DI_EXT_READOUT, 16'h9800), 4'h0, "set9");
      ask(lk(UF_SURV_ID, 3'h0, 3'h2, 16'h6800), 4'h0, "di_other");
      ask(lk(UF_COMMA_ALT, 3'h0, DI_MULTISITE, 16'hc000), 4'h0, "los_clear");
      rd(REG_LOCK_STAT, d);
      chk("lock_sites", 32'h208, d);
      ask(ac(4'h0, 4'h3), 4'h0, "locked3");
      ask(ac(4'h8, 4'h9), 4'h1, "override9");
      ask(ac(4'h0, 4'h4), 4'h1, "free4");
      chk("pi_site4", pi(w, 4'h4), {8'h0, reply_pi});
      $display("t_site done");
   endtask
   task automatic t_timer;
      logic [31:0] d;
      ask(lk(UF_SURV_ALT, 3'h0, DI_MULTISITE, 16'h3800), 4'h0, "set3");
      ask(lk(UF_SURV_ALT, 3'h0, DI_MULTISITE, 16'h9800), 4'h0, "set9");
      repeat (40) @(posedge ref_clk);
      ask(lk(UF_SURV_ALT, 3'h0, DI_MULTISITE, 16'h3800), 4'h0, "renew3");
      repeat (50) @(posedge ref_clk);
      rd(REG_LOCK_STAT, d);
      chk("lock_renewed", 32'h8, d);
      repeat (40) @(posedge ref_clk);
      rd(REG_LOCK_STAT, d);
      chk("lock_lapsed", 32'h0, d);
      $display("t_timer done");
   endtask
   task automatic t_nonsel;
      logic [31:0] d;
      ask(lk(UF_SURV_ID, PC_NONSEL_LOCK, 3'h0, 16'h0), 4'h0, "set_ns");
      rd(REG_LOCK_STAT, d);
      chk("lock_ns", 32'h1, d);
      ask(ac(4'h0, 4'h0), 4'h0, "locked_ns");
      ask(ac(4'h8, 4'h0), 4'h1, "override_ns");
      repeat (90) @(posedge ref_clk);
      ask(ac(4'h0, 4'h0), 4'h1, "lapsed_ns");
      $display("t_nonsel done");
   endtask
   task automatic t_prob;
      logic [31:0] c;
      int s;
      for (int k = 0; k < 10; k++) begin
         c = 32'h0;
         s = k % 5;
         // Codes 8..12 repeat the 0..4 probabilities with lockout ignored
         repeat (48) begin
            u_s.send(ac(4'((k < 5) ? k : k + 3), 4'h7));
            repeat (4) begin
               @(posedge ref_clk);
               #1 c += {31'h0, reply_valid};
            end
         end
         // The draw is pseudo-random, so codes 1..4 and 9..12 get only a loose band; codes 0 and 8 must answer all 48
         chk("prob_band", 32'h1, {31'h0, (s == 0) ? c == 32'h30 :
            c <= (32'h30 >> s) + 32'hc && (s > 2 || c > 32'h0)});
      end
      $display("t_prob done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #5000000;
      error_cnt++;
      give_verdict();
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      t_reset();
      t_basic();
      t_refuse();
      t_site();
      t_timer();
      t_nonsel();
      t_prob();
      give_verdict();
   end
endmodule // aca_reply_lockout_tb_top
`default_nettype wire
